// ---- core/abte_core.sv ----
`timescale 1ns/100ps
module abte_core
  import abte_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         instr_valid,
  input  abte_instr_t       instr,
  output logic              instr_ready,
  output logic              skip_nop,
  output abte_flags_t       flags,
  output logic      [7:0]   w_value,
  output logic      [6:0]   file_raddr,
  output logic              file_rd_pins,
  input  wire logic [7:0]   file_rdata,
  output abte_fwr_t         file_wr,
  input  wire logic         presc_to_timer0,
  output logic              presc_clr
);

  abte_state_t  state_r;
  abte_state_t  state_nxt;
  logic         ctrl_en_r;
  logic [7:0]   w_r;
  logic [7:0]   w_nxt;
  abte_flags_t  flags_r;
  abte_flags_t  flags_nxt;
  abte_fwr_t    fwr_r;
  abte_fwr_t    fwr_nxt;
  logic         presc_clr_r;
  logic         presc_clr_nxt;
  logic [7:0]   last_r;
  logic         last_dest_r;
  logic         skip_seen_r;

  logic         take;
  logic         exec;
  logic         is_file_byte;
  logic         is_bit_rmw;
  logic         is_test;
  logic         writes_file;
  logic         writes_w;
  logic [7:0]   fval;
  logic [7:0]   mask;
  logic [7:0]   result;
  logic         carry;
  logic         dcarry;
  logic         zero;
  logic         bit_val;
  logic         skip_taken;

  logic         apb_access;
  logic         apb_wr;
  logic         apb_rd;
  logic         addr_hit;
  logic         addr_ro;
  logic         wr_ctrl;
  logic         wr_wreg;
  logic         wr_status;
  logic [31:0]  rd_mux;

  // Instruction acceptance

  // Every instruction is consumed in one cycle; a skip slot consumes and drops one
  assign instr_ready = ctrl_en_r;
  assign take        = instr_valid && instr_ready;
  assign skip_nop    = (state_r == ST_SKIP);
  assign exec        = take && (state_r == ST_RUN);

  assign is_file_byte = (instr.op == add_file_op) || (instr.op == and_file_op);
  assign is_bit_rmw   = (instr.op == bit_clear_op) || (instr.op == bit_set_op);
  assign is_test      = (instr.op == skip_if_clear_op) || (instr.op == skip_if_set_op);

  always_comb
  begin
    writes_file = 1'b0;
    writes_w    = 1'b0;
    case (instr.op)
      add_immediate_op,
      and_immediate_op:
      begin
        writes_w = 1'b1;
      end
      add_file_op,
      and_file_op:
      begin
        writes_file = (instr.dest == DEST_FILE);
        writes_w    = (instr.dest == DEST_W);
      end
      bit_clear_op,
      bit_set_op:
      begin
        writes_file = 1'b1;
      end
      default:
      begin
        writes_file = 1'b0;
        writes_w    = 1'b0;
      end
    endcase
  end

  // File read side

  assign file_raddr   = instr.faddr;
  // Pin levels requested whenever the value read will be written back
  assign file_rd_pins = instr_valid && ((is_file_byte && instr.dest == DEST_FILE) || is_bit_rmw);

  // Forward a pending write so back-to-back access to one register sees the new value.
  // Limitation: a forwarded I/O value is the computed one, not a fresh pin sample.
  assign fval = (fwr_r.we && fwr_r.addr == instr.faddr) ? fwr_r.data : file_rdata;

  abte_bitmask #(
    .IDX_W   (BIDX_W)
  ) u_mask (
    .idx     (instr.bidx),
    .mask    (mask)
  );

  abte_alu u_alu (
    .op      (instr.op),
    .w       (w_r),
    .fval    (fval),
    .lit     (instr.lit),
    .mask    (mask),
    .result  (result),
    .carry   (carry),
    .dcarry  (dcarry),
    .zero    (zero),
    .bit_val (bit_val)
  );

  always_comb
  begin
    case (instr.op)
      skip_if_clear_op: skip_taken = exec && !bit_val;
      skip_if_set_op:   skip_taken = exec && bit_val;
      default:          skip_taken = 1'b0;
    endcase
  end

  // Skip sequencer

  always_comb
  begin
    case (state_r)
      ST_RUN:
      begin
        state_nxt = skip_taken ? ST_SKIP : ST_RUN;
      end
      ST_SKIP:
      begin
        // Waits for the discarded instruction so the skip really lasts two slots
        state_nxt = take ? ST_RUN : ST_SKIP;
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      skip_seen_r <= 1'b0;
    else if (skip_taken)
      skip_seen_r <= 1'b1;
    else if (wr_status && pwdata[STAT_SKIP_BIT])
      skip_seen_r <= 1'b0;
  end

  // Working accumulator

  always_comb
  begin
    w_nxt = w_r;
    if (exec && writes_w)
      w_nxt = result;
    else if (wr_wreg)
      w_nxt = pwdata[7:0];
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      w_r <= WREG_RST;
    else
      w_r <= w_nxt;
  end

  // Status flags; instruction updates take priority over software writes

  always_comb
  begin
    flags_nxt = flags_r;
    if (exec && (instr.op == add_immediate_op || instr.op == add_file_op))
    begin
      flags_nxt.c  = carry;
      flags_nxt.dc = dcarry;
      flags_nxt.z  = zero;
    end
    else if (exec && (instr.op == and_immediate_op || instr.op == and_file_op))
    begin
      flags_nxt.z  = zero;
    end
    else if (exec && (is_bit_rmw || is_test))
    begin
      flags_nxt = flags_r;
    end
    else if (wr_status)
    begin
      flags_nxt.c  = pwdata[STAT_C_BIT];
      flags_nxt.dc = pwdata[STAT_DC_BIT];
      flags_nxt.z  = pwdata[STAT_Z_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  // File write port and prescaler clear

  always_comb
  begin
    fwr_nxt       = '0;
    presc_clr_nxt = 1'b0;
    if (exec && writes_file)
    begin
      fwr_nxt.we    = 1'b1;
      fwr_nxt.addr  = instr.faddr;
      fwr_nxt.data  = result;
      presc_clr_nxt = (instr.faddr == TIMER0_ADDR) && presc_to_timer0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fwr_r       <= '0;
      presc_clr_r <= 1'b0;
    end
    else
    begin
      fwr_r       <= fwr_nxt;
      presc_clr_r <= presc_clr_nxt;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      last_r      <= LAST_RST;
      last_dest_r <= 1'b0;
    end
    else if (exec && (writes_w || writes_file))
    begin
      last_r      <= result;
      last_dest_r <= writes_file;
    end
  end

  assign file_wr   = fwr_r;
  assign presc_clr = presc_clr_r;
  assign flags     = flags_r;
  assign w_value   = w_r;

  // APB slave, zero wait states

  assign pready     = 1'b1;
  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite;
  assign apb_rd     = apb_access && !pwrite;

  always_comb
  begin
    addr_hit = 1'b1;
    addr_ro  = 1'b0;
    case (paddr)
      OFS_CTRL:   addr_ro = 1'b0;
      OFS_WREG:   addr_ro = 1'b0;
      OFS_STATUS: addr_ro = 1'b0;
      OFS_LAST:   addr_ro = 1'b1;
      default:    addr_hit = 1'b0;
    endcase
  end

  assign wr_ctrl   = apb_wr && (paddr == OFS_CTRL);
  assign wr_wreg   = apb_wr && (paddr == OFS_WREG);
  assign wr_status = apb_wr && (paddr == OFS_STATUS);
  // Unmapped address or a write to a read-only word is refused
  assign pslverr   = apb_access && (!addr_hit || (pwrite && addr_ro));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      ctrl_en_r <= CTRL_EN_RST;
    else if (wr_ctrl)
      ctrl_en_r <= pwdata[CTRL_EN_BIT];
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:
      begin
        rd_mux[CTRL_EN_BIT] = ctrl_en_r;
      end
      OFS_WREG:
      begin
        rd_mux[7:0] = w_r;
      end
      OFS_STATUS:
      begin
        rd_mux[STAT_C_BIT]    = flags_r.c;
        rd_mux[STAT_DC_BIT]   = flags_r.dc;
        rd_mux[STAT_Z_BIT]    = flags_r.z;
        rd_mux[STAT_SKIP_BIT] = skip_seen_r;
      end
      OFS_LAST:
      begin
        rd_mux[7:0]           = last_r;
        rd_mux[LAST_DEST_BIT] = last_dest_r;
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is held in a flop, loaded in the setup cycle
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

endmodule

// ---- core/abte_pkg.sv ----
// How it works
// - Add immediate sums W and an 8-bit literal into W, updating C, DC, Z.
// - Add file sums W and the addressed file register, result to chosen destination.
// - Destination select 0 writes W, 1 writes back the addressed file register.
// - AND immediate masks W with a literal into W, updating only Z.
// - AND file masks W with the file register, to chosen destination, only Z.
// - Bit clear forces one chosen bit of the file register to zero, flags untouched.
// - Bit set forces one chosen bit of the file register to one, flags untouched.
// - Skip-if-clear discards the next instruction when the bit is zero, two cycles.
// - Skip-if-set discards the next instruction when the bit is one, two cycles.
// - Bit tests alter no flag and never write the tested register.
// - Read-modify-write of an I/O register reads pin levels, not the latch, except back-to-back, where it takes the forwarded computed value.
// - File write of timer0 count clears the prescaler when assigned to timer0.
package abte_pkg;

  localparam int          DATA_W          = 8;
  localparam int          FADDR_W         = 7;
  localparam int          BIDX_W          = 3;
  localparam int          APB_AW          = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_WREG        = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam logic [7:0]  OFS_LAST        = 8'h0C;

  // Field positions
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          STAT_C_BIT      = 0;
  localparam int          STAT_DC_BIT     = 1;
  localparam int          STAT_Z_BIT      = 2;
  localparam int          STAT_SKIP_BIT   = 3;
  localparam int          LAST_DEST_BIT   = 8;

  // Values after reset
  localparam logic        CTRL_EN_RST     = 1'b1;
  localparam logic [7:0]  WREG_RST        = 8'h00;
  localparam logic [7:0]  LAST_RST        = 8'h00;

  // File address of the timer0 count register
  localparam logic [6:0]  TIMER0_ADDR     = 7'h01;

  // Cycles a taken skip occupies
  localparam int          SKIP_CYCLES     = 2;

  localparam logic        DEST_W          = 1'b0;
  localparam logic        DEST_FILE       = 1'b1;

  typedef enum logic [7:0] {
    add_immediate_op = 8'h01,
    add_file_op      = 8'h02,
    and_immediate_op = 8'h04,
    and_file_op      = 8'h08,
    bit_clear_op     = 8'h10,
    bit_set_op       = 8'h20,
    skip_if_clear_op = 8'h40,
    skip_if_set_op   = 8'h80
  } abte_op_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_SKIP = 2'h2
  } abte_state_t;

  typedef struct packed {
    abte_op_t          op;
    logic [6:0]        faddr;
    logic [2:0]        bidx;
    logic [7:0]        lit;
    logic              dest;
  } abte_instr_t;

  typedef struct packed {
    logic              c;
    logic              dc;
    logic              z;
  } abte_flags_t;

  typedef struct packed {
    logic              we;
    logic [6:0]        addr;
    logic [7:0]        data;
  } abte_fwr_t;

endpackage

// ---- core/abte_bitmask.sv ----
`timescale 1ns/100ps
module abte_bitmask
  import abte_pkg::*;
#(
  parameter int IDX_W = 3
)
(
  input  wire logic [IDX_W-1:0]      idx,
  output logic      [(1<<IDX_W)-1:0] mask
);

  always_comb
  begin
    mask      = '0;
    mask[idx] = 1'b1;
  end

endmodule

// ---- core/abte_alu.sv ----
`timescale 1ns/100ps
module abte_alu
  import abte_pkg::*;
(
  input  abte_op_t          op,
  input  wire logic [7:0]   w,
  input  wire logic [7:0]   fval,
  input  wire logic [7:0]   lit,
  input  wire logic [7:0]   mask,
  output logic      [7:0]   result,
  output logic              carry,
  output logic              dcarry,
  output logic              zero,
  output logic              bit_val
);

  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] nib;

  // Literal forms take k, file forms take f
  assign operand = (op == add_immediate_op || op == and_immediate_op) ? lit : fval;
  assign sum     = {1'b0, w} + {1'b0, operand};
  assign nib     = {1'b0, w[3:0]} + {1'b0, operand[3:0]};
  assign carry   = sum[8];
  assign dcarry  = nib[4];
  assign bit_val = |(fval & mask);

  always_comb
  begin
    case (op)
      add_immediate_op,
      add_file_op:      result = sum[7:0];
      and_immediate_op,
      and_file_op:      result = w & operand;
      bit_clear_op:     result = fval & ~mask;
      bit_set_op:       result = fval | mask;
      default:          result = fval;
    endcase
  end

  assign zero = (result == 8'h00);

endmodule

// ---- dv/abte_chk.sv ----
`timescale 1ns/100ps
module abte_chk
  import abte_pkg::*;
(
  input wire logic  mclk,
  input wire logic  sys_rst,
  input wire logic  instr_valid,
  input abte_instr_t instr,
  input wire logic  instr_ready,
  input wire logic  skip_nop,
  input abte_flags_t flags,
  input wire logic  [7:0] w_value,
  input wire logic  file_rd_pins,
  input wire logic  [7:0] file_rdata,
  input abte_fwr_t  file_wr,
  input wire logic  presc_to_timer0,
  input wire logic  presc_clr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic take;
  // Pending write to the same address is forwarded, so file_rdata is stale then
  assign take = instr_valid && instr_ready && !skip_nop && !(file_wr.we && file_wr.addr == instr.faddr);
  sequence op_taken(abte_op_t o);
    take && instr.op == o;
  endsequence
  add_lit_a: assert property (op_taken(add_immediate_op)
    |=> {flags.c, w_value} == $past(w_value) + $past(instr.lit)) else $error("add immediate wrong");
  and_lit_a: assert property (op_taken(and_immediate_op) |=> w_value == ($past(w_value) & $past(instr.lit))
    && flags.z == (w_value == 8'h00) && flags.c == $past(flags.c)) else $error("and immediate wrong");
  and_dst_a: assert property (op_taken(and_file_op) ##0 !instr.dest
    |=> !file_wr.we && w_value == ($past(w_value) & $past(file_rdata))) else $error("and to w wrong");
  add_file_a: assert property (op_taken(add_file_op) ##0 instr.dest |=> file_wr.we
    && file_wr.data == 8'($past(w_value) + $past(file_rdata)) && w_value == $past(w_value)) else $error("add file wrong");
  bit_clr_a: assert property (op_taken(bit_clear_op) |=> file_wr.we && flags == $past(flags)
    && file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(instr.bidx)))) else $error("bit clear wrong");
  bit_set_a: assert property (op_taken(bit_set_op) |=> file_wr.we && file_wr.addr == $past(instr.faddr)
    && file_wr.data == ($past(file_rdata) | (8'h01 << $past(instr.bidx)))) else $error("bit set wrong");
  skip_clr_a: assert property (op_taken(skip_if_clear_op) ##0 !file_rdata[instr.bidx]
    |=> skip_nop && !file_wr.we && flags == $past(flags)) else $error("skip clear wrong");
  skip_set_a: assert property (op_taken(skip_if_set_op)
    |=> skip_nop == $past(file_rdata[instr.bidx]) && w_value == $past(w_value)) else $error("skip set wrong");
  pin_read_a: assert property (instr_valid && (instr.op inside {bit_clear_op, bit_set_op}
    || instr.op inside {add_file_op, and_file_op} && instr.dest) |-> file_rd_pins) else $error("pins not read");
  presc_clr_a: assert property (presc_clr || file_wr.we && file_wr.addr == TIMER0_ADDR
    |-> presc_clr == (file_wr.we && file_wr.addr == TIMER0_ADDR && $past(presc_to_timer0))) else $error("prescaler");
endmodule
bind abte_core abte_chk u_chk (
  .mclk            (mclk),
  .sys_rst         (sys_rst),
  .instr_valid     (instr_valid),
  .instr           (instr),
  .instr_ready     (instr_ready),
  .skip_nop        (skip_nop),
  .flags           (flags),
  .w_value         (w_value),
  .file_rd_pins    (file_rd_pins),
  .file_rdata      (file_rdata),
  .file_wr         (file_wr),
  .presc_to_timer0 (presc_to_timer0),
  .presc_clr       (presc_clr)
);

// ---- dv/abte_file_model.sv ----
`timescale 1ns/100ps
module abte_file_model
  import abte_pkg::*;
#(
  parameter logic [6:0] IO_ADDR = 7'h05
)
(
  input  wire logic       mclk,
  input  wire logic [6:0] file_raddr,
  input  wire logic       file_rd_pins,
  input  abte_fwr_t       file_wr,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [128];
  initial
    for (int i = 0; i < 128; i++)
      mem[i] = 8'(i * 37 + 60);
  // Outside driver holds the low nibble against the latch
  assign file_rdata = (file_rd_pins && file_raddr == IO_ADDR) ? mem[file_raddr] ^ 8'h0F : mem[file_raddr];
  always @(posedge mclk)
    if (file_wr.we)
      mem[file_wr.addr] <= file_wr.data;
endmodule

// ---- dv/add_and_bit_test_execute_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", n, e, a); end end
module add_and_bit_test_execute_tb_top
  import abte_pkg::*;
();
  logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr, instr_valid, instr_ready;
  logic        skip_nop, file_rd_pins, presc_to_timer0, presc_clr, c, dc, z, skp, er;
  logic [7:0]  paddr, w_value, file_rdata, w;
  logic [8:0]  lst;
  logic [7:0]  fm [128];
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'h3525F14F;
  logic [6:0]  file_raddr;
  abte_instr_t instr;
  abte_flags_t flags;
  abte_fwr_t   file_wr;
  int          error_cnt, check_count;
  abte_core dut (
    .mclk            (mclk),
    .sys_rst         (sys_rst),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .instr_valid     (instr_valid),
    .instr           (instr),
    .instr_ready     (instr_ready),
    .skip_nop        (skip_nop),
    .flags           (flags),
    .w_value         (w_value),
    .file_raddr      (file_raddr),
    .file_rd_pins    (file_rd_pins),
    .file_rdata      (file_rdata),
    .file_wr         (file_wr),
    .presc_to_timer0 (presc_to_timer0),
    .presc_clr       (presc_clr)
  );
  abte_file_model model (
    .mclk            (mclk),
    .file_raddr      (file_raddr),
    .file_rd_pins    (file_rd_pins),
    .file_wr         (file_wr),
    .file_rdata      (file_rdata)
  );
  initial
  begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
        error_cnt++;
        print_verdict;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task run(input abte_op_t op, input logic [6:0] fa, input logic [2:0] b, input logic [7:0] k, input logic d);
    logic [7:0] fv, src, r;
    logic       wf, pc;
    begin
      pc = seed[20];
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= '{op, fa, b, k, d};
      presc_to_timer0 <= pc;
      @(posedge mclk);
      instr_valid <= 1'b0;
      wf = op inside {bit_clear_op, bit_set_op} || (op inside {add_file_op, and_file_op} && d);
      fv = (wf && fa == 7'h05) ? fm[fa] ^ 8'h0F : fm[fa];
      src = op inside {add_immediate_op, and_immediate_op} ? k : fv;
      r = fv;
      if (skp)
      begin
        skp = 0;
        wf = 0;
      end
      else if (op inside {add_immediate_op, add_file_op})
      begin
        {c, r} = w + src;
        dc = (w[3:0] + src[3:0]) > 15;
        z = r == 0;
        if (!wf) w = r;
        lst = {wf, r};
      end
      else if (op inside {and_immediate_op, and_file_op})
      begin
        r = w & src;
        z = r == 0;
        if (!wf) w = r;
        lst = {wf, r};
      end
      else if (op == bit_clear_op)
      begin
        r = fv & ~(8'h01 << b);
        lst = {1'b1, r};
      end
      else if (op == bit_set_op)
      begin
        r = fv | (8'h01 << b);
        lst = {1'b1, r};
      end
      else
        skp = fv[b] == (op == skip_if_set_op);
      #1;
      `CHK("w_value", w, w_value)
      `CHK("file_raddr", fa, file_raddr)
      `CHK("flags", {c, dc, z}, flags)
      `CHK("skip_nop", skp, skip_nop)
      `CHK("file_we", wf, file_wr.we)
      if (wf) `CHK("file_wr", {fa, r}, {file_wr.addr, file_wr.data})
      `CHK("presc_clr", wf && fa == TIMER0_ADDR && pc, presc_clr)
      if (wf) fm[fa] = r;
    end
  endtask
  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, instr_valid, instr, presc_to_timer0} = '0;
    {error_cnt, check_count, w, c, dc, z, skp, lst} = '0;
    for (int i = 0; i < 128; i++)
      fm[i] = 8'(i * 37 + 60);
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b1, OFS_WREG, 32'h0000_00F8);
    w = 8'hF8;
    run(add_immediate_op, 7'h00, 3'h0, 8'h08, 1'b0);
    $display("carry boundary done");
    run(bit_set_op, 7'h03, 3'h7, 8'h00, 1'b0);
    run(skip_if_set_op, 7'h03, 3'h7, 8'h00, 1'b0);
    run(add_immediate_op, 7'h00, 3'h0, 8'h55, 1'b0);
    run(skip_if_clear_op, 7'h03, 3'h7, 8'h00, 1'b0);
    run(bit_clear_op, 7'h03, 3'h7, 8'h00, 1'b0);
    run(skip_if_clear_op, 7'h03, 3'h7, 8'h00, 1'b0);
    run(and_immediate_op, 7'h00, 3'h0, 8'h00, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("skip_seen", 1'b1, rd[STAT_SKIP_BIT])
    $display("skip tests done");
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    apb(1'b1, OFS_CTRL, 32'h0);
    @(posedge mclk);
    `CHK("instr_ready", 1'b0, instr_ready)
    apb(1'b1, OFS_CTRL, 32'h1);
    $display("register tests done");
    repeat (120)
    begin
      seed = lfsr(seed);
      run(abte_op_t'(8'h01 << seed[2:0]), {4'h0, seed[5:3]}, seed[8:6], seed[16:9], seed[17]);
    end
    $display("random tests done");
    apb(1'b0, OFS_LAST, 32'h0);
    `CHK("last", {23'h0, lst}, rd)
    apb(1'b1, OFS_LAST, 32'h0);
    `CHK("read only err", 1'b1, er)
    apb(1'b0, OFS_WREG, 32'h0);
    `CHK("wreg", {24'h0, w}, rd)
    apb(1'b1, OFS_STATUS, 32'h0000_0008);
    {c, dc, z} = '0;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    $display("readback tests done");
    // Mid-run reset: the bench model forgets W, flags and any pending skip
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    {w, skp, c, dc, z} = '0;
    run(add_immediate_op, 7'h00, 3'h0, 8'h00, 1'b0);
    $display("reset test done");
    print_verdict;
  end
endmodule
